// >>> logic/pfr_pkg.sv
/*
 * Constants, register map and state type of the PID frequency regulator.
 * Assumes a 50 MHz system clock and an AXI4-Lite register bus.
 */
package pfr_pkg;

    // ************************************************
    // Timing
    // ************************************************
    localparam int unsigned CLK_HZ     = 50_000_000;
    localparam int unsigned SAMPLE_US  = 1000;
    localparam int unsigned SAMPLE_CYC = CLK_HZ / 1_000_000 * SAMPLE_US;
    // Loss time unit 0.1 s in samples
    localparam int unsigned LOSS_TICKS = 100_000 / SAMPLE_US;

    // ************************************************
    // Scaling: hundredths of a percent, 10000 = max frequency
    // ************************************************
    localparam int unsigned PCT        = 100;
    localparam int unsigned FULL_SCALE = 10000;
    localparam int unsigned ADC_W      = 12;
    localparam int unsigned CUR_ZERO   = 819;
    localparam int unsigned CUR_SCALE  = 12500;
    localparam int unsigned I_FRAC     = 10;
    localparam int unsigned Y_FRAC     = 12;

    // ************************************************
    // Register indexes (byte address = 4 * index)
    // ************************************************
    localparam int unsigned NCFG     = 14;
    localparam logic [5:0]  R_MODE   = 6'h00;
    localparam logic [5:0]  R_FBSRC  = 6'h01;
    localparam logic [5:0]  R_KP     = 6'h02;
    localparam logic [5:0]  R_TI     = 6'h03;
    localparam logic [5:0]  R_TD     = 6'h04;
    localparam logic [5:0]  R_ILIM   = 6'h05;
    localparam logic [5:0]  R_OFFS   = 6'h06;
    localparam logic [5:0]  R_FILT   = 6'h07;
    localparam logic [5:0]  R_OGAIN  = 6'h08;
    localparam logic [5:0]  R_FBGAIN = 6'h09;
    localparam logic [5:0]  R_LSEL   = 6'h0A;
    localparam logic [5:0]  R_LLVL   = 6'h0B;
    localparam logic [5:0]  R_LTIME  = 6'h0C;
    localparam logic [5:0]  R_PLIM   = 6'h0D;
    localparam logic [5:0]  R_STATUS = 6'h0E;
    localparam logic [5:0]  R_MASK   = 6'h0F;
    localparam logic [5:0]  R_CMD    = 6'h10;
    localparam logic [5:0]  R_FB     = 6'h11;

    // Reset values, index 13 first
    localparam logic [NCFG-1:0][15:0] CFG_RST = '{
        16'h0064, 16'h000A, 16'h0000, 16'h0000, 16'h0064, 16'h000A, 16'h0000,
        16'h0000, 16'h0064, 16'h0000, 16'h000A, 16'h000A, 16'h0000, 16'h0000};
    // Highest legal value, index 13 first
    localparam logic [NCFG-1:0][15:0] CFG_MAX = '{
        16'h0064, 16'h00FF, 16'h0064, 16'h0002, 16'h03E8, 16'h00FA, 16'h0064,
        16'h0064, 16'h0064, 16'h00FA, 16'h0E10, 16'h00FA, 16'h0004, 16'h0008};
    localparam int OFFS_MIN = -100;
    localparam int OFFS_MAX = 100;

    // Status bits
    localparam int unsigned NST      = 3;
    localparam int unsigned ST_LOSS  = 0;
    localparam int unsigned ST_FAULT = 1;
    localparam int unsigned ST_LIMIT = 2;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [NCFG-1:0][15:0] cfg;
        logic [NST-1:0]        status;
        logic [NST-1:0]        mask;
        logic                  aw_full;
        logic                  w_full;
        logic                  awready;
        logic                  wready;
        logic                  arready;
        logic                  bvalid;
        logic                  rvalid;
        logic [5:0]            aw_idx;
        logic [31:0]           w_data;
        logic [3:0]            w_strb;
        logic [1:0]            bresp;
        logic [1:0]            rresp;
        logic [31:0]           rdata;
        logic [15:0]           tick_cnt;
        logic signed [63:0]    i_acc;
        logic signed [63:0]    y_acc;
        logic signed [63:0]    x_prev;
        logic [15:0]           loss_cnt;
        logic                  alarm;
        logic                  active;
        logic                  irq;
        logic [15:0]           cmd;
        logic [15:0]           fbv;
    } pfr_state_t;

endpackage : pfr_pkg

// >>> logic/pfr_top.sv
/*
 * PID frequency regulator: target from the selected reference, feedback
 * from the operator analog input, output frequency command.
 * Assumes references and ADC codes come from logic on clk_i, and an
 * AXI4-Lite master that keeps the bus rules.
 */
`timescale 1ns/1ns
module pfr_top #(
    parameter int unsigned SAMPLE_CYCLES = pfr_pkg::SAMPLE_CYC
) (
    input  wire logic                     clk_i,
    input  wire logic                     reset_n_i,
    input  wire logic [7:0]               s_axi_awaddr_i,
    input  wire logic                     s_axi_awvalid_i,
    output logic                          s_axi_awready_o,
    input  wire logic [31:0]              s_axi_wdata_i,
    input  wire logic [3:0]               s_axi_wstrb_i,
    input  wire logic                     s_axi_wvalid_i,
    output logic                          s_axi_wready_o,
    output logic [1:0]                    s_axi_bresp_o,
    output logic                          s_axi_bvalid_o,
    input  wire logic                     s_axi_bready_i,
    input  wire logic [7:0]               s_axi_araddr_i,
    input  wire logic                     s_axi_arvalid_i,
    output logic                          s_axi_arready_o,
    output logic [31:0]                   s_axi_rdata_o,
    output logic [1:0]                    s_axi_rresp_o,
    output logic                          s_axi_rvalid_o,
    input  wire logic                     s_axi_rready_i,
    input  wire logic [15:0]              ref_normal_i,
    input  wire logic [15:0]              ref_local_i,
    input  wire logic [15:0]              ref_step_i,
    input  wire logic                     local_mode_i,
    input  wire logic                     step_active_i,
    input  wire logic [pfr_pkg::ADC_W-1:0] op_voltage_i,
    input  wire logic [pfr_pkg::ADC_W-1:0] op_current_i,
    output logic [15:0]                   freq_cmd_o,
    output logic                          feedback_loss_alarm_o,
    output logic                          fault_o,
    output logic                          pid_active_o,
    output logic                          irq_o
);

    pfr_pkg::pfr_state_t q;
    pfr_pkg::pfr_state_t n;

    logic               tick;
    logic               wr_go;
    logic               ff_mode;
    logic               dev_mode;
    logic               loss_now;
    logic [15:0]        wval;
    logic [15:0]        wold;
    logic [3:0]         mode;
    logic signed [63:0] tgt;
    logic signed [63:0] fbs;
    logic signed [63:0] fb_raw;
    logic signed [63:0] err;
    logic signed [63:0] xd;
    logic signed [63:0] ilim;
    logic signed [63:0] sum;
    logic signed [63:0] g;
    logic signed [63:0] y;
    logic signed [63:0] lim;
    logic signed [63:0] pl;
    logic signed [63:0] fin;

    function automatic logic signed [63:0] u64(input logic [15:0] v);
        return $signed({48'h0, v});
    endfunction : u64

    function automatic logic signed [63:0] s64(input logic [15:0] v);
        return $signed({{48{v[15]}}, v});
    endfunction : s64

    assign tick = (q.tick_cnt == 16'(SAMPLE_CYCLES - 1));
    assign mode = q.cfg[pfr_pkg::R_MODE][3:0];

    // ************************************************
    // Next state
    // ************************************************
    always_comb begin
        n        = q;
        wr_go    = 1'b0;
        wold     = 16'h0;
        wval     = 16'h0;
        loss_now = 1'b0;
        ff_mode  = (mode == 4'h3) || (mode == 4'h4) || (mode == 4'h7) || (mode == 4'h8);
        dev_mode = mode[0];

        // Bus write: address and data taken in either order
        if (s_axi_awvalid_i && q.awready) begin
            n.aw_full = 1'b1;
            n.aw_idx  = s_axi_awaddr_i[7:2];
        end
        if (s_axi_wvalid_i && q.wready) begin
            n.w_full = 1'b1;
            n.w_data = s_axi_wdata_i;
            n.w_strb = s_axi_wstrb_i;
        end
        if (q.bvalid && s_axi_bready_i) begin
            n.bvalid = 1'b0;
        end
        wr_go = q.aw_full && q.w_full && !q.bvalid;
        if (q.aw_idx < 6'(pfr_pkg::NCFG)) begin
            wold = q.cfg[q.aw_idx[3:0]];
        end
        wval = {q.w_strb[1] ? q.w_data[15:8] : wold[15:8],
                q.w_strb[0] ? q.w_data[7:0] : wold[7:0]};
        if (wr_go) begin
            n.aw_full = 1'b0;
            n.w_full  = 1'b0;
            n.bvalid  = 1'b1;
            n.bresp   = pfr_pkg::RESP_OKAY;
            if (q.aw_idx == pfr_pkg::R_OFFS) begin
                // Offset is signed, checked on its own
                if (s64(wval) >= pfr_pkg::OFFS_MIN
                    && s64(wval) <= pfr_pkg::OFFS_MAX) begin
                    n.cfg[pfr_pkg::R_OFFS] = wval;
                end else begin
                    n.bresp = pfr_pkg::RESP_SLVERR;
                end
            end else if (q.aw_idx < 6'(pfr_pkg::NCFG)) begin
                // Out-of-range settings refused, old value kept
                if (wval <= pfr_pkg::CFG_MAX[q.aw_idx[3:0]]) begin
                    n.cfg[q.aw_idx[3:0]] = wval;
                end else begin
                    n.bresp = pfr_pkg::RESP_SLVERR;
                end
            end else if (q.aw_idx == pfr_pkg::R_STATUS) begin
                n.status = q.status & ~q.w_data[pfr_pkg::NST-1:0];
            end else if (q.aw_idx == pfr_pkg::R_MASK) begin
                n.mask = q.w_data[pfr_pkg::NST-1:0];
            end else if (q.aw_idx != pfr_pkg::R_CMD && q.aw_idx != pfr_pkg::R_FB) begin
                n.bresp = pfr_pkg::RESP_SLVERR;
            end
        end

        // Bus read
        if (q.rvalid && s_axi_rready_i) begin
            n.rvalid = 1'b0;
        end
        if (s_axi_arvalid_i && q.arready) begin
            n.rvalid = 1'b1;
            n.rresp  = pfr_pkg::RESP_OKAY;
            n.rdata  = 32'h0;
            if (s_axi_araddr_i[7:2] < 6'(pfr_pkg::NCFG)) begin
                n.rdata = {16'h0, q.cfg[s_axi_araddr_i[5:2]]};
            end else if (s_axi_araddr_i[7:2] == pfr_pkg::R_STATUS) begin
                n.rdata = {29'h0, q.status};
            end else if (s_axi_araddr_i[7:2] == pfr_pkg::R_MASK) begin
                n.rdata = {29'h0, q.mask};
            end else if (s_axi_araddr_i[7:2] == pfr_pkg::R_CMD) begin
                n.rdata = {16'h0, q.cmd};
            end else if (s_axi_araddr_i[7:2] == pfr_pkg::R_FB) begin
                n.rdata = {16'h0, q.fbv};
            end else begin
                n.rresp = pfr_pkg::RESP_SLVERR;
            end
        end

        // ************************************************
        // Target and feedback
        // ************************************************
        if (step_active_i) begin
            tgt = u64(ref_step_i);
        end else if (local_mode_i) begin
            tgt = u64(ref_local_i);
        end else begin
            tgt = u64(ref_normal_i);
        end
        fb_raw = 64'sh0;
        if (q.cfg[pfr_pkg::R_FBSRC] == 16'h0003) begin
            fb_raw = ($signed({52'h0, op_voltage_i}) * pfr_pkg::FULL_SCALE)
                / ((64'sh1 <<< pfr_pkg::ADC_W) - 1);
        end else if (q.cfg[pfr_pkg::R_FBSRC] == 16'h0004
                     && op_current_i > 12'(pfr_pkg::CUR_ZERO)) begin
            fb_raw = ($signed({52'h0, op_current_i}) - pfr_pkg::CUR_ZERO) * pfr_pkg::CUR_SCALE
                / ((64'sh1 <<< pfr_pkg::ADC_W) - 1);
        end
        fbs = fb_raw * u64(q.cfg[pfr_pkg::R_FBGAIN]) / pfr_pkg::PCT;
        err = tgt - fbs;
        xd  = dev_mode ? err : -fbs;

        // ************************************************
        // PID terms, parallel form so each zero term drops alone
        // ************************************************
        ilim = u64(q.cfg[pfr_pkg::R_ILIM]) * pfr_pkg::PCT <<< pfr_pkg::I_FRAC;
        if (q.cfg[pfr_pkg::R_TI] == 16'h0) begin
            n.i_acc = 64'sh0;
        end else if (tick) begin
            // Signed divisor keeps a negative deviation from wrapping
            n.i_acc = q.i_acc + (err <<< pfr_pkg::I_FRAC)
                / (u64(q.cfg[pfr_pkg::R_TI]) * int'(pfr_pkg::PCT));
        end
        if (n.i_acc > ilim) begin
            n.i_acc = ilim;
        end else if (n.i_acc < -ilim) begin
            n.i_acc = -ilim;
        end
        sum = err * u64(q.cfg[pfr_pkg::R_KP]) / 10
            + (q.i_acc >>> pfr_pkg::I_FRAC)
            + (xd - q.x_prev) * u64(q.cfg[pfr_pkg::R_TD]) * 10
            + s64(q.cfg[pfr_pkg::R_OFFS]) * int'(pfr_pkg::PCT);
        if (mode > 4'h4) begin
            sum = -sum;
        end
        g = sum * u64(q.cfg[pfr_pkg::R_OGAIN]) / 10;
        // Filter state follows the input every cycle while off so it never lags a setting change
        if (q.cfg[pfr_pkg::R_FILT] == 16'h0) begin
            n.y_acc = g <<< pfr_pkg::Y_FRAC;
        end else if (tick) begin
            n.y_acc = q.y_acc + ((g <<< pfr_pkg::Y_FRAC) - q.y_acc)
                / (u64(q.cfg[pfr_pkg::R_FILT]) * int'(pfr_pkg::PCT));
        end
        y   = n.y_acc >>> pfr_pkg::Y_FRAC;
        lim = u64(q.cfg[pfr_pkg::R_PLIM]) * pfr_pkg::PCT;
        pl  = (y > lim) ? lim : ((y < -lim) ? -lim : y);
        fin = ff_mode ? tgt + pl : pl;
        if (mode == 4'h0) begin
            fin     = tgt;
            n.i_acc = 64'sh0;
            n.y_acc = 64'sh0;
        end

        // ************************************************
        // Sample update
        // ************************************************
        n.tick_cnt = tick ? 16'h0 : q.tick_cnt + 16'h1;
        n.active   = (mode != 4'h0);
        if (tick) begin
            n.x_prev = xd;
            n.fbv    = (fbs > 64'sh0000FFFF) ? 16'hFFFF : fbs[15:0];
            if (fin < 0) begin
                n.cmd = 16'h0;
            end else if (fin > pfr_pkg::FULL_SCALE) begin
                n.cmd = 16'(pfr_pkg::FULL_SCALE);
            end else begin
                n.cmd = fin[15:0];
            end
            if (n.active && (y > lim || y < -lim)) begin
                n.status[pfr_pkg::ST_LIMIT] = 1'b1;
            end
            // Loss detector counts samples below level
            if (n.active && q.cfg[pfr_pkg::R_LSEL] != 16'h0
                && fbs < u64(q.cfg[pfr_pkg::R_LLVL]) * pfr_pkg::PCT) begin
                n.loss_cnt = (q.loss_cnt == 16'hFFFF) ? q.loss_cnt : q.loss_cnt + 16'h1;
            end else begin
                n.loss_cnt = 16'h0;
            end
        end
        loss_now = u64(q.loss_cnt) > u64(q.cfg[pfr_pkg::R_LTIME]) * pfr_pkg::LOSS_TICKS;
        n.alarm  = loss_now && q.cfg[pfr_pkg::R_LSEL] == 16'h0001;
        if (n.alarm && !q.alarm) begin
            n.status[pfr_pkg::ST_LOSS] = 1'b1;
        end
        // Fault latches until software clears it; a set wins over the clear
        if (loss_now && q.cfg[pfr_pkg::R_LSEL] == 16'h0002) begin
            n.status[pfr_pkg::ST_FAULT] = 1'b1;
        end
        if (n.status[pfr_pkg::ST_FAULT]) begin
            n.cmd = 16'h0;
        end

        n.awready = !n.aw_full;
        n.wready  = !n.w_full;
        n.arready = !n.rvalid;
        n.irq     = |(n.status & n.mask);
    end

    // ************************************************
    // State register
    // ************************************************
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            q         <= '0;
            q.cfg     <= pfr_pkg::CFG_RST;
            q.awready <= 1'b1;
            q.wready  <= 1'b1;
            q.arready <= 1'b1;
        end else begin
            q <= n;
        end
    end

    assign s_axi_awready_o       = q.awready;
    assign s_axi_wready_o        = q.wready;
    assign s_axi_bresp_o         = q.bresp;
    assign s_axi_bvalid_o        = q.bvalid;
    assign s_axi_arready_o       = q.arready;
    assign s_axi_rdata_o         = q.rdata;
    assign s_axi_rresp_o         = q.rresp;
    assign s_axi_rvalid_o        = q.rvalid;
    assign freq_cmd_o            = q.cmd;
    assign feedback_loss_alarm_o = q.alarm;
    assign fault_o               = q.status[pfr_pkg::ST_FAULT];
    assign pid_active_o          = q.active;
    assign irq_o                 = q.irq;

    // ************************************************
    // Assertions
    // ************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    sequence wr_both;
        q.aw_full && q.w_full && !q.bvalid;
    endsequence
    sequence wr_done;
        q.bvalid && !q.aw_full && !q.w_full;
    endsequence

    mode_off_cmd_a: assert property (
        tick && mode == 4'h0 && !q.status[pfr_pkg::ST_FAULT] && tgt <= pfr_pkg::FULL_SCALE
        |=> q.cmd == $past(tgt[15:0]))
        else $error("bypass command differs from target");
    ff_passthru_a: assert property (
        tick && ff_mode && q.cfg[pfr_pkg::R_KP] == 16'h0 && q.cfg[pfr_pkg::R_TI] == 16'h0
        && q.cfg[pfr_pkg::R_TD] == 16'h0 && q.cfg[pfr_pkg::R_OFFS] == 16'h0
        && q.cfg[pfr_pkg::R_FILT] == 16'h0 && q.i_acc == 64'sh0
        && !q.status[pfr_pkg::ST_FAULT] && tgt <= pfr_pkg::FULL_SCALE
        |=> q.cmd == $past(tgt[15:0]))
        else $error("feedforward with zero terms not equal to target");
    zero_floor_a: assert property (
        tick && q.active && mode != 4'h0 && !ff_mode && pl < 0
        |=> q.cmd == 16'h0)
        else $error("negative output not clamped");
    pid_limit_a: assert property (
        tick && mode != 4'h0 && !ff_mode
        |=> 32'(q.cmd) <= 32'($past(q.cfg[pfr_pkg::R_PLIM])) * pfr_pkg::PCT)
        else $error("output above limit");
    int_clamp_a: assert property (
        (q.i_acc >>> pfr_pkg::I_FRAC) <= u64(q.cfg[pfr_pkg::R_ILIM]) * int'(pfr_pkg::PCT)
        || $changed(q.cfg[pfr_pkg::R_ILIM]))
        else $error("integral above limit");
    loss_time_a: assert property (
        $rose(q.alarm)
        |-> u64(q.loss_cnt) > u64(q.cfg[pfr_pkg::R_LTIME]) * pfr_pkg::LOSS_TICKS)
        else $error("loss alarm before time elapsed");
    fault_off_a: assert property (
        q.status[pfr_pkg::ST_FAULT]
        |-> q.cmd == 16'h0 ##1 (q.cmd == 16'h0 || !q.status[pfr_pkg::ST_FAULT]))
        else $error("output on during fault");
    write_answer_a: assert property (wr_both |=> wr_done)
        else $error("write not answered in one cycle");
    read_answer_a: assert property (
        s_axi_arvalid_i && q.arready |=> q.rvalid && !q.arready)
        else $error("read not answered in one cycle");

endmodule : pfr_top

// >>> test/pfr_ref_model.sv
/*
 * Model of the reference sources and the operator analog input.
 * Assumes the bench sets the wanted values; they reach the block one edge later.
 */
`timescale 1ns/1ns
module pfr_ref_model (
    input  wire logic        clk_i,
    input  wire logic [47:0] ref_set_i,
    input  wire logic [1:0]  src_set_i,
    input  wire logic [23:0] adc_set_i,
    output logic      [15:0] ref_normal_o,
    output logic      [15:0] ref_local_o,
    output logic      [15:0] ref_step_o,
    output logic             local_mode_o,
    output logic             step_active_o,
    output logic      [11:0] op_voltage_o,
    output logic      [11:0] op_current_o
);
    // Sources change only on the clock, like the real selector logic
    always_ff @(posedge clk_i) begin
        ref_normal_o  <= ref_set_i[15:0];
        ref_local_o   <= ref_set_i[31:16];
        ref_step_o    <= ref_set_i[47:32];
        local_mode_o  <= src_set_i[0];
        step_active_o <= src_set_i[1];
        op_voltage_o  <= adc_set_i[11:0];
        op_current_o  <= adc_set_i[23:12];
    end
endmodule : pfr_ref_model

// >>> test/tb_pid_frequency_regulator.sv
/*
 * Self-checking bench of the PID frequency regulator.
 * Assumes a 50-cycle sample period and the reference model on the inputs.
 */
`timescale 1ns/1ns
module tb_pid_frequency_regulator;
    localparam int TK = 50;
    logic        clk_i;
    logic        reset_n_i;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, seed;
    logic        awv, wv, bready, arv, rready;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [47:0] ref_set;
    logic [1:0]  src_set;
    logic [23:0] adc_set;
    logic [15:0] rn, rl, rs, cmd;
    logic [11:0] ov, oc;
    logic        lm, sa, alarm, fault, act, irq;
    int          mismatches = 0;
    int          n_tests = 0;
    int          cyc = 0;

    pfr_ref_model u_pfr_ref_model (.clk_i(clk_i), .ref_set_i(ref_set), .src_set_i(src_set),
        .adc_set_i(adc_set), .ref_normal_o(rn), .ref_local_o(rl), .ref_step_o(rs),
        .local_mode_o(lm), .step_active_o(sa), .op_voltage_o(ov), .op_current_o(oc));
    pfr_top #(.SAMPLE_CYCLES(TK)) u_pfr_top (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awv), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arv),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .ref_normal_i(rn),
        .ref_local_i(rl), .ref_step_i(rs), .local_mode_i(lm), .step_active_i(sa),
        .op_voltage_i(ov), .op_current_i(oc), .freq_cmd_o(cmd),
        .feedback_loss_alarm_o(alarm), .fault_o(fault), .pid_active_o(act), .irq_o(irq));

    // ************************************************
    // Clock, watchdog and helpers
    // ************************************************
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            mismatches++;
            $display("Timeout");
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %0d seen %0d", n, e, g);
        end
    endtask : chk

    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction : xs

    // Reference result with integral, derivative and filter held off
    function automatic int exp_cmd(int m, int t, int fb, int kp, int of, int og, int pl);
        int y;
        if (m == 0) return (t > 10000) ? 10000 : t;
        y = ((t - fb) * kp) / 10 + of * 100;
        if (m > 4) y = -y;
        y = y * og / 10;
        if (y > pl * 100) y = pl * 100;
        if (y < -pl * 100) y = -pl * 100;
        if (m % 4 == 3 || m % 4 == 0) y = y + t;
        if (y < 0) y = 0;
        return (y > 10000) ? 10000 : y;
    endfunction : exp_cmd

    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk_i);
        awaddr <= a;
        wdata  <= d;
        awv    <= 1'b1;
        wv     <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge clk_i);
            if (awv && awready) awv <= 1'b0;
            if (wv && wready) wv <= 1'b0;
            if (bvalid) begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk_i);
        araddr <= a;
        arv    <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge clk_i);
            if (arv && arready) arv <= 1'b0;
            if (rvalid) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask : rd

    task automatic cfg(input logic [5:0] i, input int v);
        logic [1:0] r;
        wr({i, 2'b00}, v, r);
        chk("bresp", pfr_pkg::RESP_OKAY, r);
    endtask : cfg

    task automatic ticks(input int n);
        repeat (n * TK) @(posedge clk_i);
    endtask : ticks

    // ************************************************
    // Main sequence
    // ************************************************
    initial begin
        int i, k, t;
        logic [31:0] d;
        logic [1:0] r;
        int dft[14] = '{0, 0, 10, 10, 0, 100, 0, 0, 10, 100, 0, 0, 10, 100};
        int tab[4][5] = '{'{0, 0, 10, 100, 4000}, '{0, 20, 10, 100, 0},
                          '{10, 0, 20, 100, 1000}, '{10, 0, 10, 30, 5000}};
        reset_n_i = 1'b0;
        {awaddr, araddr, wdata, awv, wv, bready, arv, rready} = '0;
        {ref_set, src_set, adc_set} = '0;
        seed = 32'h0000000A;
        repeat (8) @(posedge clk_i);
        reset_n_i <= 1'b1;
        for (i = 0; i < 14; i++) begin
            rd({i[5:0], 2'b00}, d, r);
            chk("default", dft[i], d);
        end
        rd(8'h48, d, r);
        chk("unmapped resp", pfr_pkg::RESP_SLVERR, r);
        chk("unmapped data", 0, d);
        wr(8'h00, 9, r);
        chk("mode 9 resp", pfr_pkg::RESP_SLVERR, r);
        rd(8'h00, d, r);
        chk("mode kept", 0, d);
        $display("test registers done");
        for (k = 0; k < 4; k++) begin
            for (i = 0; i < 3; i++) begin
                seed = xs(seed);
                ref_set[i*16 +: 16] <= 16'(seed % 12000);
            end
            src_set <= 2'(k);
            ticks(3);
            t = k[1] ? ref_set[47:32] : k[0] ? ref_set[31:16] : ref_set[15:0];
            chk("bypass", exp_cmd(0, t, 0, 0, 0, 0, 0), cmd);
            chk("idle", 0, act);
        end
        src_set <= 2'b00;
        cfg(pfr_pkg::R_FBSRC, 3);
        cfg(pfr_pkg::R_TI, 0);
        for (k = 1; k < 9; k++) begin
            seed = xs(seed);
            t = seed % 10001;
            ref_set[15:0] <= 16'(t);
            cfg(pfr_pkg::R_MODE, k);
            ticks(3);
            chk("mode cmd", exp_cmd(k, t, 0, 10, 0, 10, 100), cmd);
            chk("active", 1, act);
        end
        $display("test modes done");
        cfg(pfr_pkg::R_MODE, 1);
        for (k = 0; k < 4; k++) begin
            cfg(pfr_pkg::R_KP, tab[k][0]);
            cfg(pfr_pkg::R_OFFS, tab[k][1]);
            cfg(pfr_pkg::R_OGAIN, tab[k][2]);
            cfg(pfr_pkg::R_PLIM, tab[k][3]);
            ref_set[15:0] <= 16'(tab[k][4]);
            ticks(3);
            chk("shaping", exp_cmd(1, tab[k][4], 0, tab[k][0], tab[k][1], tab[k][2],
                tab[k][3]), cmd);
        end
        cfg(pfr_pkg::R_PLIM, 100);
        adc_set <= 24'h000FFF;
        cfg(pfr_pkg::R_FBGAIN, 50);
        ref_set[15:0] <= 16'h1F40;
        ticks(3);
        rd(8'h44, d, r);
        chk("feedback", 5000, d);
        chk("fb cmd", exp_cmd(1, 8000, 5000, 10, 0, 10, 100), cmd);
        cfg(pfr_pkg::R_FBSRC, 4);
        adc_set <= 24'h333FFF;
        ticks(3);
        rd(8'h44, d, r);
        chk("current 4mA", 0, d);
        cfg(pfr_pkg::R_FBSRC, 3);
        adc_set <= 24'h000000;
        $display("test feedback done");
        cfg(pfr_pkg::R_KP, 0);
        cfg(pfr_pkg::R_TI, 1);
        cfg(pfr_pkg::R_ILIM, 20);
        ref_set[15:0] <= 16'h1388;
        ticks(100);
        chk("integral clamp", 2000, cmd);
        cfg(pfr_pkg::R_MODE, 0);
        cfg(pfr_pkg::R_TI, 0);
        cfg(pfr_pkg::R_ILIM, 100);
        cfg(pfr_pkg::R_KP, 10);
        cfg(pfr_pkg::R_FILT, 10);
        cfg(pfr_pkg::R_MODE, 1);
        ticks(5);
        chk("filtered", 1, 32'(cmd > 0 && cmd < 2500));
        cfg(pfr_pkg::R_FILT, 0);
        $display("test integral and filter done");
        cfg(pfr_pkg::R_LSEL, 1);
        cfg(pfr_pkg::R_LLVL, 10);
        cfg(pfr_pkg::R_LTIME, 1);
        cfg(pfr_pkg::R_MASK, 1);
        ticks(95);
        chk("alarm early", 0, alarm);
        ticks(15);
        chk("alarm", 1, alarm);
        chk("irq", 1, irq);
        rd(8'h38, d, r);
        chk("loss status", 1, d[0]);
        cfg(pfr_pkg::R_MASK, 0);
        repeat (3) @(posedge clk_i);
        chk("irq masked", 0, irq);
        adc_set <= 24'h000FFF;
        ticks(3);
        chk("alarm gone", 0, alarm);
        cfg(pfr_pkg::R_STATUS, 1);
        rd(8'h38, d, r);
        chk("status cleared", 0, d[0]);
        cfg(pfr_pkg::R_LSEL, 2);
        adc_set <= 24'h000000;
        ticks(110);
        chk("fault", 1, fault);
        chk("fault cmd", 0, cmd);
        $display("test loss done");
        stop_test();
    end
endmodule : tb_pid_frequency_regulator
